// *** logic/sevg_system_event_vector_generator.sv ***
// System event vector generator: latches event sources and encodes them into three vector registers.
// Assumes event inputs are one-cycle pulses or levels from logic on clk; the pin event is asynchronous.
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module sevg_system_event_vector_generator
  import sevg_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  // Event sources
  input wire logic [NUM_RST-1:0] resetEvent,
  input wire logic [NUM_SNMI-1:0] systemEvent,
  input wire logic [NUM_UNMI-1:0] userEvent,
  input wire logic externalPinRaw,
  // Debug mailbox side
  input wire logic [15:0] debugMailboxWdata,
  input wire logic debugMailboxWrite,
  input wire logic debugMailboxRead,
  output logic [15:0] debugMailboxRdata,
  // Interrupt and reset class outputs
  output logic irq,
  output logic systemNmiReq,
  output logic userNmiReq,
  output logic powerOnClass,
  output logic powerUpClearClass
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NUM_RST-1:0] rstPend;
    logic [NUM_SNMI-1:0] snmiPend;
    logic [NUM_UNMI-1:0] unmiPend;
    logic [2:0] intStatus;
    logic [2:0] intMask;
    logic [2:0] nmiSelect;
    logic [15:0] mailboxIn;
    logic [15:0] mailboxOut;
    logic [1:0] pinSync;
    logic pinLast;
    logic [15:0] rdata;
    logic [15:0] dbgRdata;
    logic irq;
    logic sNmi;
    logic uNmi;
    logic porClass;
    logic pucClass;
  } sevg_state_t;

  sevg_state_t st;
  sevg_state_t next_st;

  // ----------------------------------------
  // Priority encoders
  // ----------------------------------------
  // Returns index of lowest set bit, or width when none
  function automatic logic [4:0] first_set(input logic [15:0] v, input int n);
    logic [4:0] idx;
    idx = 5'(n);
    for (int i = n - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : first_set

  logic [4:0] rstIdx;
  logic [4:0] snmiIdx;
  logic [4:0] unmiIdx;
  logic [7:0] rstCode;
  logic [7:0] snmiCode;
  logic [7:0] unmiCode;
  logic [NUM_RST-1:0] rstSet;
  logic [NUM_SNMI-1:0] snmiSet;
  logic [NUM_UNMI-1:0] unmiSet;
  logic pinRise;
  logic [1:0] srcClass;

  always_comb begin
    // Reserved slot is masked so code 1Ch never appears
    rstSet = resetEvent;
    rstSet[RSRC_RESERVED] = 1'b0;
    rstIdx = first_set(16'(st.rstPend), NUM_RST);
    snmiIdx = first_set(16'(st.snmiPend), NUM_SNMI);
    unmiIdx = first_set(16'(st.unmiPend), NUM_UNMI);
    // Code is twice the one-based position: always even, low byte only
    rstCode = (rstIdx == 5'(NUM_RST)) ? CODE_NONE : {2'h0, rstIdx + 5'h01, 1'b0};
    snmiCode = (snmiIdx == 5'(NUM_SNMI)) ? CODE_NONE : {2'h0, snmiIdx + 5'h01, 1'b0};
    unmiCode = (unmiIdx == 5'(NUM_UNMI)) ? CODE_NONE : {2'h0, unmiIdx + 5'h01, 1'b0};
    pinRise = st.pinSync[1] & ~st.pinLast;
    snmiSet = systemEvent;
    snmiSet[SSRC_MAILBOX_IN] = systemEvent[SSRC_MAILBOX_IN] | debugMailboxWrite;
    snmiSet[SSRC_MAILBOX_OUT] = systemEvent[SSRC_MAILBOX_OUT] | debugMailboxRead;
    unmiSet = userEvent;
    unmiSet[0] = userEvent[0] | pinRise;
    srcClass = (rstIdx == 5'(NUM_RST)) ? CLASS_BROWNOUT : RST_CLASS_MAP[2*rstIdx[3:0] +: 2];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [2:0] irqEvent;
  logic [15:0] rdVal;

  always_comb begin
    next_st = st;
    irqEvent = '0;
    rdVal = 16'h0000;
    next_st.pinSync = {st.pinSync[0], externalPinRaw};
    next_st.pinLast = st.pinSync[1];

    // Register read; vector and status reads clear what they report
    if (regRead) begin
      case (regAddr)
        OFS_RESET_CAUSE_VECTOR: begin
          rdVal = {8'h00, rstCode};
          if (rstIdx != 5'(NUM_RST)) begin
            next_st.rstPend[rstIdx[3:0]] = 1'b0;
          end
        end
        OFS_SYSTEM_NMI_VECTOR: begin
          rdVal = {8'h00, snmiCode};
          if (snmiIdx != 5'(NUM_SNMI)) begin
            next_st.snmiPend[snmiIdx[3:0]] = 1'b0;
          end
        end
        OFS_USER_NMI_VECTOR: begin
          rdVal = {8'h00, unmiCode};
          if (unmiIdx != 5'(NUM_UNMI)) begin
            next_st.unmiPend[unmiIdx[1:0]] = 1'b0;
          end
        end
        OFS_INT_STATUS: begin
          rdVal = {13'h0000, st.intStatus};
          next_st.intStatus = 3'h0;
        end
        OFS_INT_MASK: begin
          rdVal = {13'h0000, st.intMask};
        end
        OFS_NMI_SELECT: begin
          rdVal = {13'h0000, st.nmiSelect};
        end
        OFS_MAILBOX_IN: begin
          rdVal = st.mailboxIn;
        end
        OFS_MAILBOX_OUT: begin
          rdVal = st.mailboxOut;
        end
        OFS_RESET_CLASS: begin
          rdVal = {14'h0000, srcClass};
        end
        default: begin
          rdVal = 16'h0000;
        end
      endcase
    end
    next_st.rdata = rdVal;

    // Register write
    if (regWrite) begin
      case (regAddr)
        OFS_INT_MASK: begin
          next_st.intMask = regWdata[2:0];
        end
        OFS_NMI_SELECT: begin
          next_st.nmiSelect = regWdata[2:0];
        end
        OFS_MAILBOX_OUT: begin
          next_st.mailboxOut = regWdata;
        end
        default: begin
        end
      endcase
    end

    // Debug port side of the mailbox
    if (debugMailboxWrite) begin
      next_st.mailboxIn = debugMailboxWdata;
    end
    next_st.dbgRdata = st.mailboxOut;

    // Sources set after the read clear, so a same-cycle event is kept
    next_st.rstPend = next_st.rstPend | rstSet;
    next_st.snmiPend = next_st.snmiPend | snmiSet;
    next_st.unmiPend = next_st.unmiPend | unmiSet;

    irqEvent[IRQ_RST_BIT] = |rstSet;
    irqEvent[IRQ_SNMI_BIT] = |snmiSet;
    irqEvent[IRQ_UNMI_BIT] = |unmiSet;
    next_st.intStatus = next_st.intStatus | irqEvent;

    next_st.irq = |(next_st.intStatus & next_st.intMask);
    next_st.sNmi = st.nmiSelect[1] & (|next_st.snmiPend);
    next_st.uNmi = st.nmiSelect[2] & (|next_st.unmiPend);
    next_st.porClass = (srcClass == CLASS_POWER_ON) | (srcClass == CLASS_BROWNOUT && |st.rstPend);
    next_st.pucClass = (srcClass == CLASS_POWER_UP_CLEAR);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.intMask <= RST_INT_MASK;
      st.nmiSelect <= RST_NMI_SELECT;
      st.mailboxIn <= RST_MAILBOX;
      st.mailboxOut <= RST_MAILBOX;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata = st.rdata;
  assign debugMailboxRdata = st.dbgRdata;
  assign irq = st.irq;
  assign systemNmiReq = st.sNmi;
  assign userNmiReq = st.uNmi;
  assign powerOnClass = st.porClass;
  assign powerUpClearClass = st.pucClass;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_rst_idle_zero: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend == '0 |=> regRdata == 16'h0000)
    else $error("reset vector not zero when idle");
  a_brownout_first: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[RSRC_BROWNOUT] |=> regRdata == 16'h0002)
    else $error("brownout not reported first");
  a_pin_after_bor: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[1:0] == 2'b10 |=> regRdata == 16'h0004)
    else $error("pin reset code wrong");
  a_wdt_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[10:0] == 11'h400 |=> regRdata == 16'h0016)
    else $error("watchdog code wrong");
  a_no_reserved: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    |=> regRdata != 16'h001C)
    else $error("reserved code produced");
  a_pm_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend == 16'h8000 |=> regRdata == 16'h0020)
    else $error("power manager code wrong");
  a_snmi_top: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    && st.snmiPend[0] |=> regRdata == 16'h0002)
    else $error("system vector priority wrong");
  a_snmi_last: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    && st.snmiPend == 9'h100 |=> regRdata == 16'h0012)
    else $error("supply regulator code wrong");
  a_unmi_code: assert property (regRead && regAddr == OFS_USER_NMI_VECTOR
    && st.unmiPend == 3'h4 |=> regRdata == 16'h0006)
    else $error("flash access code wrong");
  a_read_clears: assert property (regRead && regAddr == OFS_USER_NMI_VECTOR
    && st.unmiPend == 3'h1 && userEvent == '0 && !pinRise |=> st.unmiPend == 3'h0)
    else $error("read did not clear source");
  a_mbox_flag: assert property (debugMailboxWrite
    |=> st.snmiPend[SSRC_MAILBOX_IN])
    else $error("mailbox in flag not raised");
  a_even_low: assert property (regRead
    && (regAddr == OFS_RESET_CAUSE_VECTOR || regAddr == OFS_SYSTEM_NMI_VECTOR)
    |=> regRdata[0] == 1'b0 && regRdata[15:8] == 8'h00)
    else $error("vector not even low byte");
  a_puc_class: assert property (st.rstPend == 16'h0400
    |=> powerUpClearClass)
    else $error("power-up-clear class missing");

  // ----------------------------------------
  // Table entries and side effects
  // ----------------------------------------
  a_rdata_idle: assert property (!regRead
    |=> regRdata == 16'h0000)
    else $error("read data not zero between reads");
  a_security_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[4:0] == 5'h10 |=> regRdata == 16'h000A)
    else $error("security violation code wrong");
  a_sw_por_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[9:0] == 10'h200 |=> regRdata == 16'h0014)
    else $error("software power-on code wrong");
  a_wdt_pw_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[11:0] == 12'h800 |=> regRdata == 16'h0018)
    else $error("watchdog password code wrong");
  a_flash_pw_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[12:0] == 13'h1000 |=> regRdata == 16'h001A)
    else $error("flash password code wrong");
  a_fetch_code: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend[14:0] == 15'h4000 |=> regRdata == 16'h001E)
    else $error("peripheral fetch code wrong");
  a_reserved_never: assert property (st.rstPend[RSRC_RESERVED] == 1'b0)
    else $error("reserved reset slot pending");
  a_rst_range: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    |=> (regRdata <= 16'h0020))
    else $error("reset vector beyond last code");
  a_snmi_idle: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    && st.snmiPend == '0 |=> regRdata == 16'h0000)
    else $error("system vector not zero when idle");
  a_snmi_delay: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    && st.snmiPend[3:0] == 4'h8 |=> regRdata == 16'h0008)
    else $error("supply delay code wrong");
  a_snmi_vacant: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    && st.snmiPend[4:0] == 5'h10 |=> regRdata == 16'h000A)
    else $error("vacant access code wrong");
  a_snmi_range: assert property (regRead && regAddr == OFS_SYSTEM_NMI_VECTOR
    |=> (regRdata <= 16'h0012) && regRdata[0] == 1'b0)
    else $error("system vector beyond last code");
  a_unmi_idle: assert property (regRead && regAddr == OFS_USER_NMI_VECTOR
    && st.unmiPend == '0 |=> regRdata == 16'h0000)
    else $error("user vector not zero when idle");
  a_unmi_top: assert property (regRead && regAddr == OFS_USER_NMI_VECTOR
    && st.unmiPend[0] |=> regRdata == 16'h0002)
    else $error("pin event not reported first");
  a_unmi_range: assert property (regRead && regAddr == OFS_USER_NMI_VECTOR
    |=> (regRdata <= 16'h0006) && regRdata[0] == 1'b0)
    else $error("user vector beyond last code");
  a_mbox_out_flag: assert property (debugMailboxRead
    |=> st.snmiPend[SSRC_MAILBOX_OUT])
    else $error("mailbox out flag not raised");
  a_mbox_word: assert property (debugMailboxWrite
    |=> st.mailboxIn == $past(debugMailboxWdata))
    else $error("mailbox in word not taken");
  a_rst_read_clears: assert property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR
    && st.rstPend == 16'h0001 && resetEvent == '0 |=> st.rstPend == '0)
    else $error("reset read did not clear source");
  a_status_clear: assert property (regRead && regAddr == OFS_INT_STATUS && resetEvent == '0
    && systemEvent == '0 && userEvent == '0 && !debugMailboxWrite && !debugMailboxRead && !pinRise
    |=> st.intStatus == 3'h0)
    else $error("status read did not clear");
  a_pin_event: assert property (pinRise
    |=> st.unmiPend[0])
    else $error("pin edge not latched");
  a_por_class: assert property (st.rstPend == 16'h0200
    |=> powerOnClass && !powerUpClearClass)
    else $error("power-on class missing");
  a_snmi_req: assert property (systemNmiReq == ($past(st.nmiSelect[1]) & (|st.snmiPend)))
    else $error("system request does not follow selection");
  a_unmi_req: assert property (userNmiReq == ($past(st.nmiSelect[2]) & (|st.unmiPend)))
    else $error("user request does not follow selection");
  a_irq_level: assert property (irq == (|(st.intStatus & st.intMask)))
    else $error("interrupt level wrong");

  c_brownout_read: cover property (regRead && regAddr == OFS_RESET_CAUSE_VECTOR && st.rstPend[RSRC_BROWNOUT]);
  c_mailbox_in: cover property (debugMailboxWrite ##1 regRead && regAddr == OFS_SYSTEM_NMI_VECTOR);
  c_pin_event: cover property (pinRise ##[1:4] userNmiReq);
  c_irq: cover property (irq ##1 regRead && regAddr == OFS_INT_STATUS);
  c_class_read: cover property (powerOnClass ##1 regRead && regAddr == OFS_RESET_CLASS);

endmodule : sevg_system_event_vector_generator

// *** logic/sevg_pkg.sv ***
// Constants for the system event vector generator: register offsets, event codes, field layout.
// Assumes a plain word-addressed register port on the system clock.
package sevg_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int ADDR_W = 16;
  localparam logic [15:0] OFS_USER_NMI_VECTOR = 16'h019A;
  localparam logic [15:0] OFS_SYSTEM_NMI_VECTOR = 16'h019C;
  localparam logic [15:0] OFS_RESET_CAUSE_VECTOR = 16'h019E;
  localparam logic [15:0] OFS_INT_STATUS = 16'h0190;
  localparam logic [15:0] OFS_INT_MASK = 16'h0192;
  localparam logic [15:0] OFS_NMI_SELECT = 16'h0194;
  localparam logic [15:0] OFS_MAILBOX_IN = 16'h0196;
  localparam logic [15:0] OFS_MAILBOX_OUT = 16'h0198;
  localparam logic [15:0] OFS_RESET_CLASS = 16'h018E;

  // ----------------------------------------
  // Source counts and reset values
  // ----------------------------------------
  localparam int NUM_RST = 16;
  localparam int NUM_SNMI = 9;
  localparam int NUM_UNMI = 3;
  localparam logic [2:0] RST_INT_MASK = 3'h0;
  localparam logic [2:0] RST_NMI_SELECT = 3'h7;
  localparam logic [15:0] RST_MAILBOX = 16'h0000;

  // Reset source indices, highest priority first; code = 2*(index+1) except reserved slot
  localparam int RSRC_BROWNOUT = 0;
  localparam int RSRC_PIN = 1;
  localparam int RSRC_SW_BOR = 2;
  localparam int RSRC_SHUTDOWN_WAKE = 3;
  localparam int RSRC_SECURITY = 4;
  localparam int RSRC_CORE_SVS = 5;
  localparam int RSRC_SUPPLY_SVS = 6;
  localparam int RSRC_CORE_OVP = 7;
  localparam int RSRC_SUPPLY_OVP = 8;
  localparam int RSRC_SW_POR = 9;
  localparam int RSRC_WDT_TIMEOUT = 10;
  localparam int RSRC_WDT_PASSWORD = 11;
  localparam int RSRC_FLASH_PASSWORD = 12;
  localparam int RSRC_RESERVED = 13;
  localparam int RSRC_PERIPH_FETCH = 14;
  localparam int RSRC_PM_PASSWORD = 15;

  // Class of each reset source: 0 brownout, 1 power-on, 2 power-up-clear
  localparam logic [31:0] RST_CLASS_MAP = 32'hAAA5_5404;
  localparam logic [1:0] CLASS_BROWNOUT = 2'h0;
  localparam logic [1:0] CLASS_POWER_ON = 2'h1;
  localparam logic [1:0] CLASS_POWER_UP_CLEAR = 2'h2;

  // System NMI source indices
  localparam int SSRC_MAILBOX_IN = 5;
  localparam int SSRC_MAILBOX_OUT = 6;

  // Interrupt status bit positions
  localparam int IRQ_RST_BIT = 0;
  localparam int IRQ_SNMI_BIT = 1;
  localparam int IRQ_UNMI_BIT = 2;

  localparam logic [7:0] CODE_NONE = 8'h00;

endpackage : sevg_pkg

// *** test/sevg_system_event_vector_generator_bench.sv ***
// Self-checking bench for the system event vector generator: table of single events, then hand-written cases.
// Assumes the design package, a 20 MHz clock and the plain register port with read data one cycle late.
`timescale 1ns/1ps
`define SEVG_CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errorCnt++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module sevg_system_event_vector_generator_bench
  import sevg_pkg::*;
;
  // ----------------------------------------
  // Signals and instance
  // ----------------------------------------
  logic clk, rstn, regWrite, regRead, externalPinRaw, debugMailboxWrite, debugMailboxRead;
  logic irq, systemNmiReq, userNmiReq, powerOnClass, powerUpClearClass;
  logic [15:0] regAddr, regWdata, regRdata, debugMailboxWdata, debugMailboxRdata;
  logic [NUM_RST-1:0] resetEvent;
  logic [NUM_SNMI-1:0] systemEvent;
  logic [NUM_UNMI-1:0] userEvent;
  int errorCnt = 0;
  int comparisons = 0;
  // Row: [15:14] vector (0 reset, 1 system, 2 user), [11:8] source bit, [7:0] expected code
  localparam logic [15:0] ROWS [27] = '{16'h0002, 16'h0104, 16'h0206, 16'h0308, 16'h040A, 16'h050C, 16'h060E,
    16'h0710, 16'h0812, 16'h0914, 16'h0A16, 16'h0B18, 16'h0C1A, 16'h0E1E, 16'h0F20, 16'h4002, 16'h4104, 16'h4206,
    16'h4308, 16'h440A, 16'h450C, 16'h460E, 16'h4710, 16'h4812, 16'h8002, 16'h8104, 16'h8206};

  sevg_system_event_vector_generator i_dut (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .resetEvent(resetEvent),
    .systemEvent(systemEvent), .userEvent(userEvent), .externalPinRaw(externalPinRaw),
    .debugMailboxWdata(debugMailboxWdata), .debugMailboxWrite(debugMailboxWrite),
    .debugMailboxRead(debugMailboxRead), .debugMailboxRdata(debugMailboxRdata), .irq(irq),
    .systemNmiReq(systemNmiReq), .userNmiReq(userNmiReq), .powerOnClass(powerOnClass),
    .powerUpClearClass(powerUpClearClass));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------
  // Bus and event tasks
  // ----------------------------------------
  function automatic logic [15:0] vecAddr(input logic [1:0] sel);
    return (sel == 2'd0) ? OFS_RESET_CAUSE_VECTOR : (sel == 2'd1) ? OFS_SYSTEM_NMI_VECTOR : OFS_USER_NMI_VECTOR;
  endfunction : vecAddr

  // Strobe is dropped after the edge and raised again by the next call, so reads may follow each other with no gap
  task automatic rc(input logic [15:0] a, input logic [15:0] e, input string nm);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1;
    `SEVG_CHK(nm, e, regRdata)
  endtask : rc

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr

  task automatic pulse(input logic [1:0] sel, input logic [15:0] bits);
    if (sel == 2'd0) resetEvent <= bits;
    if (sel == 2'd1) systemEvent <= bits[NUM_SNMI-1:0];
    if (sel == 2'd2) userEvent <= bits[NUM_UNMI-1:0];
    @(posedge clk);
    resetEvent <= '0;
    systemEvent <= '0;
    userEvent <= '0;
    @(posedge clk);
    #1;
  endtask : pulse

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errorCnt++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0; regWrite = 1'b0; regRead = 1'b0; regAddr = '0; regWdata = '0; externalPinRaw = 1'b0;
    debugMailboxWrite = 1'b0; debugMailboxRead = 1'b0; debugMailboxWdata = '0;
    resetEvent = '0; systemEvent = '0; userEvent = '0;
    repeat (5) @(posedge clk);
    `SEVG_CHK("regRdata in reset", 16'h0000, regRdata)
    rstn <= 1'b1;
    @(posedge clk);
    for (int s = 0; s < 3; s++) rc(vecAddr(s[1:0]), 16'h0000, "idle vector");
    foreach (ROWS[k]) begin
      pulse(ROWS[k][15:14], 16'h0001 << ROWS[k][11:8]);
      rc(vecAddr(ROWS[k][15:14]), {8'h00, ROWS[k][7:0]}, "single event code");
      rc(vecAddr(ROWS[k][15:14]), 16'h0000, "vector after read");
    end
    // Every source at once: back-to-back reads must walk down the priority list, skipping 1Ch
    for (int s = 0; s < 3; s++) begin
      pulse(s[1:0], 16'hFFFF);
      foreach (ROWS[k]) if (ROWS[k][15:14] == s[1:0]) rc(vecAddr(s[1:0]), {8'h00, ROWS[k][7:0]}, "burst");
      rc(vecAddr(s[1:0]), 16'h0000, "burst drained");
    end
    // Reset classes of the top cause
    pulse(2'd0, 16'h0400);
    `SEVG_CHK("powerUpClearClass", 1'b1, powerUpClearClass)
    rc(OFS_RESET_CLASS, {14'h0, CLASS_POWER_UP_CLEAR}, "class watchdog");
    rc(OFS_RESET_CAUSE_VECTOR, 16'h0016, "watchdog code");
    pulse(2'd0, 16'h0002);
    `SEVG_CHK("powerOnClass", 1'b1, powerOnClass)
    rc(OFS_RESET_CLASS, {14'h0, CLASS_POWER_ON}, "class pin");
    rc(OFS_RESET_CAUSE_VECTOR, 16'h0004, "pin code");
    // Unmapped read and writes to read-only places are ignored
    rc(16'h0000, 16'h0000, "unmapped read");
    wr(OFS_RESET_CAUSE_VECTOR, 16'hFFFF);
    rc(OFS_RESET_CAUSE_VECTOR, 16'h0000, "vector after write");
    // Mailbox both ways
    debugMailboxWdata <= 16'hA5C3;
    debugMailboxWrite <= 1'b1;
    @(posedge clk);
    debugMailboxWrite <= 1'b0;
    @(posedge clk);
    #1;
    `SEVG_CHK("systemNmiReq", 1'b1, systemNmiReq)
    rc(OFS_SYSTEM_NMI_VECTOR, 16'h000C, "mailbox in flag");
    wr(OFS_MAILBOX_IN, 16'h1234);
    rc(OFS_MAILBOX_IN, 16'hA5C3, "mailbox in word");
    debugMailboxRead <= 1'b1;
    @(posedge clk);
    debugMailboxRead <= 1'b0;
    @(posedge clk);
    rc(OFS_SYSTEM_NMI_VECTOR, 16'h000E, "mailbox out flag");
    wr(OFS_MAILBOX_OUT, 16'h3C5A);
    repeat (2) @(posedge clk);
    #1;
    `SEVG_CHK("debugMailboxRdata", 16'h3C5A, debugMailboxRdata)
    // Asynchronous pin passes a two-stage synchroniser
    externalPinRaw <= 1'b1;
    repeat (6) @(posedge clk);
    rc(OFS_USER_NMI_VECTOR, 16'h0002, "pin event");
    externalPinRaw <= 1'b0;
    rc(OFS_USER_NMI_VECTOR, 16'h0000, "pin event read");
    // Reset in mid-run with sources pending
    pulse(2'd0, 16'hFFFF);
    pulse(2'd1, 16'hFFFF);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    `SEVG_CHK("systemNmiReq in reset", 1'b0, systemNmiReq)
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int s = 0; s < 3; s++) rc(vecAddr(s[1:0]), 16'h0000, "vector after reset");
    rc(OFS_NMI_SELECT, {13'h0, RST_NMI_SELECT}, "select reset value");
    // Interrupt: raised only when unmasked, cleared by the status read
    pulse(2'd2, 16'h0002);
    `SEVG_CHK("irq masked", 1'b0, irq)
    `SEVG_CHK("userNmiReq", 1'b1, userNmiReq)
    wr(OFS_NMI_SELECT, 16'h0003);
    repeat (2) @(posedge clk);
    `SEVG_CHK("userNmiReq deselected", 1'b0, userNmiReq)
    wr(OFS_INT_MASK, 16'h0004);
    repeat (2) @(posedge clk);
    `SEVG_CHK("irq unmasked", 1'b1, irq)
    rc(OFS_INT_STATUS, 16'h0004, "status");
    @(posedge clk);
    #1;
    `SEVG_CHK("irq after status read", 1'b0, irq)
    rc(OFS_USER_NMI_VECTOR, 16'h0004, "oscillator code");
    conclude();
  end
endmodule : sevg_system_event_vector_generator_bench
